// *** inc/psl_pkg.sv ***
// constants, states and timing for the passive serial configuration loader
package psl_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_SYS_HZ          = 50_000_000;
    localparam int unsigned POR_DELAY_MS        = 100;
    localparam int unsigned POR_DELAY_CYC       = (CLK_SYS_HZ / 1000) * POR_DELAY_MS;
    localparam int unsigned ERR_TIMEOUT_US      = 40;
    localparam int unsigned ERR_TIMEOUT_CYC     = (CLK_SYS_HZ / 1_000_000) * ERR_TIMEOUT_US;
    localparam int unsigned OSC_HZ              = 10_000_000;
    localparam int unsigned OSC_DIV_CYC         = CLK_SYS_HZ / OSC_HZ;
    localparam int unsigned DONE_TO_USER_US     = 18;
    localparam int unsigned DONE_TO_USER_CYC    = (CLK_SYS_HZ / 1_000_000) * DONE_TO_USER_US;
    localparam int unsigned USER_INIT_CYCLES    = 299;

    // ----------------------------------------------------------------
    // bitstream framing
    // ----------------------------------------------------------------
    localparam int unsigned BITSTREAM_BITS      = 1024;
    localparam int unsigned FRAME_BITS          = 32;
    localparam int unsigned FRAME_WORDS         = BITSTREAM_BITS / FRAME_BITS;
    localparam int unsigned OPT_INIT_DONE_BIT   = 0;
    localparam int unsigned OPT_USER_CLK_BIT    = 1;
    localparam int unsigned OPT_AUTO_RESTART_BIT = 2;
    localparam logic [31:0] CHECK_SEED          = 32'h0000_0000;

    typedef enum logic [2:0] {
        PSL_POR,
        PSL_RESET,
        PSL_LOAD,
        PSL_ERROR,
        PSL_INIT,
        PSL_USER
    } psl_state_t;

endpackage : psl_pkg

// *** rtl/psl_frame_mem.sv ***
// small frame store for received configuration words, registered read
`timescale 1ns/1ps
module psl_frame_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_sys_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule : psl_frame_mem

// *** rtl/psl_loader.sv ***
// passive serial configuration loader: reset, load, initialization, user mode
//
// Notes on behaviour
// R1: power-on holds status and done low, user pins tri-stated, status released after 100 ms.
// R2: weak pull-ups on user pins until user mode, then removed; the code keeps them off during the power-on delay.
// R3: source runs own power-on delay holding status low, 100 ms or 2 ms; the source model holds it for 3000 ns.
// R4: device stays in reset while config request or status line is low.
// R5: rising config request leaves reset, releases status; then ready for data.
// R6: cycle runs reset, serial load, initialization in order after supplies valid.
// R7: source shifts bitstream with its own clock once status is high.
// R8: one bit sampled from serial input on each serial clock rising edge.
// R9: whole bitstream without error releases done line, starting initialization.
// R10: done line drives source select; source stops while done is high.
// R11: default initialization runs from internal 10 MHz oscillator; user clock pin free.
// R12: user clock option needs 299 user clock cycles after done rises.
// R13: user clock activity has no effect during serial loading.
// R14: init-finished floats high early, driven low after first frame, released in user mode.
// R15: without init-finished, init ends after 299 user cycles or fixed delay.
// R16: outside system must not pull done low to postpone initialization.
// R17: user clock must keep toggling while status low after mid-init request pulse.
// R18: source parks serial clock low and data high after loading.
// R19: reconfiguration request must stay low at least 2 us.
// R20: falling request pulls status and done low, tri-states all user pins.
// R21: load error pulls status low; auto-restart releases it after 40 us.
// R22: source waits 64 serial clocks for done, else forces status low.
// R23: initialization count follows selected clock, cleared on every reset entry.
`timescale 1ns/1ps
module psl_loader
    import psl_pkg::*;
#(
    parameter int unsigned POR_CYC     = POR_DELAY_CYC,
    parameter int unsigned STREAM_BITS = BITSTREAM_BITS,
    parameter int unsigned WORD_BITS   = FRAME_BITS,
    parameter int unsigned USER_PINS   = 8
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 rstn_in,
    input  wire logic                 config_req_n_in,
    input  wire logic                 status_n_in,
    input  wire logic                 load_done_in,
    input  wire logic                 serial_load_clock_in,
    input  wire logic                 serial_load_input_in,
    input  wire logic                 user_startup_clock_in,
    input  wire logic [USER_PINS-1:0] user_pin_data_in,
    input  wire logic [USER_PINS-1:0] user_pin_oe_in,
    output logic                      status_n_out,
    output logic                      status_n_oe_out,
    output logic                      load_done_out,
    output logic                      load_done_oe_out,
    output logic                      init_finished_out,
    output logic                      init_finished_oe_out,
    output logic [USER_PINS-1:0]      user_pin_out,
    output logic [USER_PINS-1:0]      user_pin_oe_out,
    output logic                      user_pullup_en_out,
    output logic                      user_mode_out,
    output logic [WORD_BITS-1:0]      frame_word_out,
    output logic                      load_error_out
);
    localparam int WORDS = STREAM_BITS / WORD_BITS;
    localparam int WAW   = $clog2(WORDS);
    localparam int BAW   = $clog2(WORD_BITS);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] req_sync, st_sync, serial_load_clock_sync, data_sync, uclk_sync, done_sync;
    logic       serial_load_clock_prev, uclk_prev;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_sync  <= 2'h0;
            st_sync   <= 2'h0;
            serial_load_clock_sync <= 2'h0;
            data_sync <= 2'h0;
            uclk_sync <= 2'h0;
            done_sync <= 2'h0;
        end else begin
            req_sync  <= {req_sync[0], config_req_n_in};
            st_sync   <= {st_sync[0], status_n_in};
            serial_load_clock_sync <= {serial_load_clock_sync[0], serial_load_clock_in};
            data_sync <= {data_sync[0], serial_load_input_in};
            uclk_sync <= {uclk_sync[0], user_startup_clock_in};
            done_sync <= {done_sync[0], load_done_in};
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            serial_load_clock_prev <= 1'b0;
            uclk_prev <= 1'b0;
        end else begin
            serial_load_clock_prev <= serial_load_clock_sync[1];
            uclk_prev <= uclk_sync[1];
        end
    end

    wire req_n    = req_sync[1];
    wire st_line  = st_sync[1];
    wire serial_load_clock_rise = serial_load_clock_sync[1] & ~serial_load_clock_prev;
    wire uclk_rise = uclk_sync[1] & ~uclk_prev;
    wire done_line = done_sync[1];

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    psl_state_t state, next_state;
    logic [31:0] tmr;
    logic        tmr_zero;
    logic [WAW-1:0] word_cnt;
    logic [BAW-1:0] bit_cnt;
    logic [WORD_BITS-1:0] shift;
    logic [31:0] check;
    logic        opt_init_done, opt_user_clk, opt_auto_restart, opt_valid;
    logic        stream_end;
    logic [8:0]  init_cnt;
    logic [2:0]  osc_div;
    logic        init_tick, init_over;

    assign tmr_zero   = (tmr == 32'h0000_0000);
    wire   word_full  = serial_load_clock_rise && (bit_cnt == BAW'(WORD_BITS - 1));
    wire [WORD_BITS-1:0] word_new = {shift[WORD_BITS-2:0], data_sync[1]};
    assign stream_end = word_full && (word_cnt == WAW'(WORDS - 1));
    // the last word is a check against the running sum of the stream
    wire   stream_ok  = (word_new == check[WORD_BITS-1:0]);

    always_comb begin
        next_state = state;
        unique case (state)
            PSL_POR: if (tmr_zero) next_state = PSL_RESET; // R1
            PSL_RESET: if (req_n && st_line) next_state = PSL_LOAD; // R4 R5 R6
            PSL_LOAD: begin
                if (stream_end) next_state = stream_ok ? PSL_INIT : PSL_ERROR; // R9 R21
            end
            PSL_ERROR: begin
                if (opt_auto_restart && tmr_zero) next_state = PSL_RESET; // R21
            end
            PSL_INIT: if (init_over) next_state = PSL_USER; // R15
            PSL_USER: next_state = PSL_USER;
        endcase
        if (state != PSL_POR && state != PSL_ERROR && (!req_n || (!st_line && state != PSL_RESET))) begin
            next_state = PSL_RESET; // R4 R20
        end
        if (state == PSL_ERROR && !req_n) begin
            next_state = PSL_RESET; // R20
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= PSL_POR;
        end else begin
            state <= next_state;
        end
    end

    // single down-counter serves power-on delay and error time-out
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tmr <= 32'(POR_CYC); // R1
        end else if (state == PSL_LOAD && stream_end && !stream_ok) begin
            tmr <= 32'(ERR_TIMEOUT_CYC); // R21
        end else if (!tmr_zero) begin
            tmr <= tmr - 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // serial receive
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_cnt  <= '0;
            word_cnt <= '0;
            shift    <= '0;
            check    <= CHECK_SEED;
        end else if (state != PSL_LOAD) begin
            bit_cnt  <= '0;
            word_cnt <= '0;
            check    <= CHECK_SEED;
        end else if (serial_load_clock_rise) begin
            shift   <= word_new; // R8
            bit_cnt <= bit_cnt + BAW'(1);
            if (word_full) begin
                word_cnt <= word_cnt + WAW'(1);
                check    <= check + 32'(word_new);
            end
        end
    end

    // options arrive in the first frame
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            opt_init_done    <= 1'b0;
            opt_user_clk     <= 1'b0;
            opt_auto_restart <= 1'b0;
            opt_valid        <= 1'b0;
        end else if (state == PSL_RESET) begin
            opt_valid <= 1'b0;
        end else if (state == PSL_LOAD && word_full && word_cnt == '0) begin
            opt_init_done    <= word_new[OPT_INIT_DONE_BIT]; // R14
            opt_user_clk     <= word_new[OPT_USER_CLK_BIT];
            opt_auto_restart <= word_new[OPT_AUTO_RESTART_BIT];
            opt_valid        <= 1'b1;
        end
    end

    psl_frame_mem #(
        .WIDTH (WORD_BITS),
        .DEPTH (WORDS)
    ) u_frame_mem (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (state == PSL_LOAD && word_full),
        .wr_addr_in  (word_cnt),
        .wr_data_in  (word_new),
        .rd_addr_in  (word_cnt),
        .rd_data_out (frame_word_out)
    );

    // ----------------------------------------------------------------
    // initialization clocking
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_div <= 3'h0;
        end else if (osc_div == 3'(OSC_DIV_CYC - 1)) begin
            osc_div <= 3'h0;
        end else begin
            osc_div <= osc_div + 3'h1;
        end
    end

    // user clock is looked at only in initialization, never while loading
    assign init_tick = opt_user_clk ? uclk_rise : (osc_div == 3'h0); // R11 R13
    assign init_over = opt_user_clk ? (init_cnt == 9'(USER_INIT_CYCLES)) // R12
                                    : (init_cnt == 9'(DONE_TO_USER_CYC / OSC_DIV_CYC));

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_cnt <= 9'h000;
        end else if (state != PSL_INIT) begin
            init_cnt <= 9'h000; // R23
        end else if (init_tick && done_line && !init_over) begin
            init_cnt <= init_cnt + 9'h001; // R23
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    assign status_n_out         = 1'b0;
    assign status_n_oe_out      = (state == PSL_POR) || (state == PSL_ERROR) || !req_n; // R1 R20 R21
    assign load_done_out        = 1'b0;
    assign load_done_oe_out     = (state != PSL_INIT) && (state != PSL_USER); // R1 R9 R20
    assign init_finished_out    = 1'b0;
    assign init_finished_oe_out = opt_valid && opt_init_done && (state != PSL_USER); // R14
    // user mode ends as soon as a low request is seen, with status pulled low
    assign user_mode_out        = (state == PSL_USER) && req_n; // R20
    assign user_pullup_en_out   = (state != PSL_USER) && (state != PSL_POR); // R2
    assign load_error_out       = (state == PSL_ERROR);

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            user_pin_out    <= '0;
            user_pin_oe_out <= '0; // R1
        end else if (state == PSL_USER && req_n) begin
            user_pin_out    <= user_pin_data_in; // R2
            user_pin_oe_out <= user_pin_oe_in;
        end else begin
            user_pin_oe_out <= '0; // R20
        end
    end

endmodule : psl_loader

// *** test/psl_loader_chk.sv ***
// concurrent checks on the loader's pins
`timescale 1ns/1ps
module psl_loader_chk
    import psl_pkg::*;
#(
    parameter int unsigned POR_CYC   = 50,
    parameter int unsigned USER_PINS = 8
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 rstn_in,
    input  wire logic                 config_req_n_in,
    input  wire logic [USER_PINS-1:0] user_pin_data_in,
    input  wire logic [USER_PINS-1:0] user_pin_oe_in,
    input  wire logic                 status_n_oe_out,
    input  wire logic                 load_done_oe_out,
    input  wire logic                 init_finished_oe_out,
    input  wire logic [USER_PINS-1:0] user_pin_out,
    input  wire logic [USER_PINS-1:0] user_pin_oe_out,
    input  wire logic                 user_pullup_en_out,
    input  wire logic                 user_mode_out,
    input  wire logic                 load_error_out
);
    // -----------------------------------------------------------
    // helper counters
    // -----------------------------------------------------------
    localparam int MIN_INIT = DONE_TO_USER_CYC - 20;
    logic [31:0] por_cnt;
    logic [11:0] done_cnt;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            por_cnt <= '0;
        end else if (por_cnt < POR_CYC) begin
            por_cnt <= por_cnt + 1;
        end
    end
    // saturates so a long user-clock wait never wraps back below the floor
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_cnt <= '0;
        end else if (load_done_oe_out) begin
            done_cnt <= '0;
        end else if (done_cnt != 12'hfff) begin
            done_cnt <= done_cnt + 1;
        end
    end
    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    por_hold_a: assert property (por_cnt < POR_CYC |-> status_n_oe_out)
        else $error("status released during power-on delay");
    pins_tri_a: assert property (!user_mode_out && $past(!user_mode_out) |->
        user_pin_oe_out == '0) else $error("user pin driven outside user mode");
    pullup_off_a: assert property (user_mode_out |-> !user_pullup_en_out)
        else $error("pull-ups on in user mode");
    req_fall_a: assert property ($fell(config_req_n_in) |-> ##[1:6]
        status_n_oe_out && load_done_oe_out) else $error("request fall not obeyed");
    req_hold_a: assert property (!config_req_n_in [*5] |-> status_n_oe_out)
        else $error("status released while request low");
    pin_follow_a: assert property (user_mode_out && $past(user_mode_out) |->
        user_pin_oe_out == $past(user_pin_oe_in) && user_pin_out == $past(user_pin_data_in))
        else $error("user pins do not follow design");
    user_lines_a: assert property (user_mode_out |-> !load_done_oe_out && !status_n_oe_out)
        else $error("user mode with a line pulled low");
    init_fin_a: assert property (user_mode_out |-> !init_finished_oe_out)
        else $error("init-finished held low in user mode");
    error_hold_a: assert property (load_error_out |-> status_n_oe_out && load_done_oe_out)
        else $error("error without status and done low");
    init_delay_a: assert property ($rose(user_mode_out) |-> done_cnt >= MIN_INIT)
        else $error("user mode too soon after done");
endmodule : psl_loader_chk

bind psl_loader psl_loader_chk #(.POR_CYC(POR_CYC), .USER_PINS(USER_PINS)) i_psl_loader_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .config_req_n_in(config_req_n_in),
    .user_pin_data_in(user_pin_data_in), .user_pin_oe_in(user_pin_oe_in),
    .status_n_oe_out(status_n_oe_out), .load_done_oe_out(load_done_oe_out),
    .init_finished_oe_out(init_finished_oe_out), .user_pin_out(user_pin_out),
    .user_pin_oe_out(user_pin_oe_out), .user_pullup_en_out(user_pullup_en_out),
    .user_mode_out(user_mode_out), .load_error_out(load_error_out));

// *** test/psl_loader_test.sv ***
// self-checking bench for the serial loader against a serial source model
`timescale 1ns/1ps
module psl_loader_test
    import psl_pkg::*;
;
    localparam int BITS = 128;
    localparam int NW   = BITS / 32;
    logic            clk, rstn, req_n, ucl, sclk, sdat, src_low;
    logic            st_oe, dn_oe, if_oe, pull, umode, err;
    logic [7:0]      pdat, poe, pin_o, pin_oe;
    logic            st_o, dn_o, if_o;
    logic [31:0]     fw;
    logic [31:0]     words[$];
    logic [BITS-1:0] stream;
    wire             status_w = !(st_oe | src_low);
    int              errors, total_checks, n;

    psl_source_model #(.BITS(BITS)) i_psl_source_model (.status_wire_in(status_w),
        .source_select_n_in(!dn_oe), .stream_in(stream), .serial_load_clock_out(sclk),
        .serial_load_input_out(sdat), .oe_pull_low_out(src_low));
    psl_loader #(.POR_CYC(50), .STREAM_BITS(BITS)) i_psl_loader (.clk_sys_in(clk),
        .rstn_in(rstn), .config_req_n_in(req_n), .status_n_in(status_w),
        .load_done_in(!dn_oe), .serial_load_clock_in(sclk), .serial_load_input_in(sdat),
        .user_startup_clock_in(ucl), .user_pin_data_in(pdat), .user_pin_oe_in(poe),
        .status_n_out(st_o), .status_n_oe_out(st_oe), .load_done_out(dn_o),
        .load_done_oe_out(dn_oe), .init_finished_out(if_o),
        .init_finished_oe_out(if_oe), .user_pin_out(pin_o),
        .user_pin_oe_out(pin_oe), .user_pullup_en_out(pull), .user_mode_out(umode),
        .frame_word_out(fw), .load_error_out(err));

    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    function automatic logic sig(input int w);
        case (w)
            0: return dn_oe;
            1: return umode;
            2: return err;
            default: return st_oe;
        endcase
    endfunction : sig
    task wait_on(input int w, input logic v, input int lim);
        n = 0;
        while (sig(w) !== v) begin
            if (n >= lim) begin
                errors++;
                $display("Error wait %0d timed out", w);
                give_verdict();
            end
            @(negedge clk);
            n++;
        end
    endtask : wait_on
    // word 0 carries options, the last word is the sum of all before it plus the bad flag
    task build(input logic [31:0] opts, input bit bad);
        logic [31:0] w, sum;
        sum = 0;
        words.delete();
        for (int i = 0; i < NW; i++) begin
            w = (i == 0) ? opts : $urandom;
            if (i == NW - 1) w = sum + bad;
            sum += w;
            words.push_back(w);
            stream[BITS-1-32*i -: 32] = w;
        end
    endtask : build
    task start(input logic [31:0] opts, input bit bad);
        build(opts, bad);
        req_n = 0;
        repeat (100) @(negedge clk);
        check("reset_lines", {st_oe, dn_oe, |pin_oe}, 3'h6);
        req_n = 1;
        wait_on(3, 0, 200);
        check("config_pins", {pull, |pin_oe, umode}, 3'h4);
    endtask : start
    // user clock runs without gaps until the pulse count is spent
    task uclk(input int k);
        repeat (k) begin
            #80 ucl = 1;
            #80 ucl = 0;
        end
    endtask : uclk

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        void'($urandom(31402));
        rstn = 0;
        req_n = 0;
        ucl = 0;
        pdat = $urandom;
        poe = $urandom;
        stream = '0;
        repeat (16) @(negedge clk);
        check("por_lines", {st_oe, dn_oe, |pin_oe}, 3'h6);
        rstn = 1;
        start(32'h0000_0001, 0);
        wait_on(0, 0, 3000);
        check("init_fin_low", if_oe, 1);
        wait_on(1, 1, 2000);
        check("osc_delay", n >= DONE_TO_USER_CYC - 20 && n <= DONE_TO_USER_CYC + 20, 1);
        pdat = $urandom;
        poe = $urandom;
        repeat (2) @(negedge clk);
        check("user_pins", {pin_oe, pin_o, pull, if_oe}, {poe, pdat, 2'h0});
        check("od_levels", {st_o, dn_o, if_o}, 3'h0);
        check("frame_word", fw, words[0]);
        // user clock pulses while loading must not count toward start-up
        start(32'h0000_0002, 0);
        fork
            uclk(100);
        join_none
        wait_on(0, 0, 3000);
        check("ucl_in_load", umode, 0);
        repeat (500) @(negedge clk);
        check("ucl_withheld", umode, 0);
        uclk(298);
        repeat (8) @(negedge clk);
        check("ucl_298", umode, 0);
        uclk(1);
        wait_on(1, 1, 20);
        check("ucl_299", umode, 1);
        // bad check word with auto-restart, clean stream on the retry
        start(32'h0000_0004, 1);
        wait_on(2, 1, 3000);
        check("err_lines", {st_oe, dn_oe}, 2'h3);
        build(32'h0000_0004, 0);
        wait_on(3, 0, 2200);
        check("err_timeout", n >= ERR_TIMEOUT_CYC - 10 && n <= ERR_TIMEOUT_CYC + 10, 1);
        wait_on(0, 0, 3000);
        wait_on(1, 1, 1000);
        check("restart_user", {umode, err}, 2'h2);
        check("frame_retry", fw, words[0]);
        give_verdict();
    end
endmodule : psl_loader_test

// *** test/psl_source_model.sv ***
// serial configuration source model: power-on delay, bit shifting, done watch
`timescale 1ns/1ps
module psl_source_model #(
    parameter int BITS    = 128,
    parameter int POR_NS  = 3000,
    parameter int HALF_NS = 80
) (
    input  wire logic            status_wire_in,
    input  wire logic            source_select_n_in,
    input  wire logic [BITS-1:0] stream_in,
    output logic                 serial_load_clock_out,
    output logic                 serial_load_input_out,
    output logic                 oe_pull_low_out
);
    int n;
    initial begin
        serial_load_clock_out = 1'b0;
        serial_load_input_out = 1'b1;
        oe_pull_low_out = 1'b1;
        #(POR_NS);
        oe_pull_low_out = 1'b0;
        forever begin
            wait (status_wire_in && !source_select_n_in);
            #1000;
            for (int i = BITS - 1; i >= 0; i--) begin
                if (!status_wire_in || source_select_n_in) break;
                serial_load_input_out = stream_in[i];
                #(HALF_NS) serial_load_clock_out = 1'b1;
                #(HALF_NS) serial_load_clock_out = 1'b0;
            end
            serial_load_input_out = 1'b1;
            n = 0;
            // done never rose: force status low so the device restarts, which it ignores while in its error state
            while (n < 64 && !source_select_n_in) begin
                #(2 * HALF_NS);
                n++;
            end
            if (!source_select_n_in) begin
                oe_pull_low_out = 1'b1;
                #2000 oe_pull_low_out = 1'b0;
            end
            wait (!status_wire_in || source_select_n_in);
        end
    end
endmodule : psl_source_model
